// File: hdl/pcacr_defs.svh
// Address map, field positions and reset values of the counter-array register block.
`ifndef PCACR_DEFS_SVH
`define PCACR_DEFS_SVH

// ============================================================================
// Register addresses on the special-function-register bus
`define PCACR_ADDR_CNT_LO   8'hF9
`define PCACR_ADDR_CNT_HI   8'hFA
`define PCACR_ADDR_MODE0    8'hDA
`define PCACR_ADDR_CPL0     8'hFB
`define PCACR_ADDR_CPH0     8'hFC
`define PCACR_ADDR_CPL1     8'hE9
`define PCACR_ADDR_CPH1     8'hEA
`define PCACR_ADDR_CPL2     8'hEB
`define PCACR_ADDR_CPH2     8'hEC
`define PCACR_ADDR_CPL3     8'hED
`define PCACR_ADDR_CPH3     8'hEE
`define PCACR_ADDR_CPL4     8'hFD
`define PCACR_ADDR_CPH4     8'hFE
`define PCACR_ADDR_CPL5     8'hCE
`define PCACR_ADDR_CPH5     8'hCF

// ============================================================================
// Fields, sizes and reset values
`define PCACR_NUM_MOD       6
`define PCACR_WDT_MOD       5
`define PCACR_CMP_EN_BIT    6
`define PCACR_RELOAD_BASE   5'h0C
`define PCACR_MEM_DEPTH     24
`define PCACR_RST_BYTE      8'h00
`define PCACR_RST_WORD      16'h0000
`define PCACR_UNMAPPED      8'h00

`endif

// File: hdl/pcacr_pkg.sv
// Types shared by the counter-array register block.
package pcacr_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pcacr_sfr_req_t;

    typedef struct packed {
        logic       en;
        logic [4:0] idx;
        logic [7:0] data;
    } pcacr_mem_wr_t;

endpackage

// File: hdl/pcacr_ccmem.sv
// Byte store for the capture/compare and auto-reload values of all modules.
`timescale 1ns/1ps
`include "pcacr_defs.svh"

module pcacr_ccmem (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Write port
    input  wire pcacr_pkg::pcacr_mem_wr_t wr,
    // Read port
    input  wire logic                  rd_en,
    input  wire logic [4:0]            rd_idx,
    output logic [7:0]                 rd_data,
    // Stored values, module m in bits 16*m+15 down to 16*m
    output logic [95:0]                cc_values,
    output logic [95:0]                reload_values
);

    logic [7:0] mem_ff     [0:`PCACR_MEM_DEPTH-1];
    logic [7:0] nxt_mem    [0:`PCACR_MEM_DEPTH-1];
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;

    // ========================================================================
    // Storage
    always_comb begin
        for (int i = 0; i < `PCACR_MEM_DEPTH; i++) begin
            nxt_mem[i] = mem_ff[i];
        end
        if (wr.en && (wr.idx < 5'(`PCACR_MEM_DEPTH))) begin
            nxt_mem[wr.idx] = wr.data;
        end
        nxt_rd_data = rd_data_ff;
        if (rd_en) begin
            nxt_rd_data = (rd_idx < 5'(`PCACR_MEM_DEPTH)) ? mem_ff[rd_idx] : `PCACR_UNMAPPED;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `PCACR_MEM_DEPTH; i++) begin
                mem_ff[i] <= `PCACR_RST_BYTE;
            end
            rd_data_ff <= `PCACR_RST_BYTE;
        end else begin
            for (int i = 0; i < `PCACR_MEM_DEPTH; i++) begin
                mem_ff[i] <= nxt_mem[i];
            end
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;

    // ========================================================================
    // Flattened views
    for (genvar m = 0; m < `PCACR_NUM_MOD; m++) begin : g_view
        assign cc_values[16*m +: 16]     = {mem_ff[2*m+1], mem_ff[2*m]};
        assign reload_values[16*m +: 16] = {mem_ff[12+2*m+1], mem_ff[12+2*m]};
    end

endmodule // pcacr_ccmem

// File: hdl/pcacr_top.sv
// Register access logic of the programmable counter array.
`timescale 1ns/1ps
`include "pcacr_defs.svh"

module pcacr_top (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Register bus, one request per cycle
    input  wire pcacr_pkg::pcacr_sfr_req_t sfr_req,
    output logic [7:0]                    sfr_rdata,
    output logic                          sfr_rvalid,
    // Control bits from elsewhere in the array
    input  wire logic                     wdt_enable,
    input  wire logic                     reload_select,
    input  wire logic                     cnt_inc,
    // Register contents for the counting and compare logic
    output logic [15:0]                   array_counter,
    output logic [5:0]                    compare_enable,
    output logic [47:0]                   mode_regs,
    output logic [95:0]                   cc_values,
    output logic [95:0]                   reload_values
);

    logic [15:0] counter_ff;
    logic [15:0] nxt_counter;
    logic [7:0]  snap_ff;
    logic [7:0]  nxt_snap;
    logic [7:0]  mode_ff     [0:`PCACR_NUM_MOD-1];
    logic [7:0]  nxt_mode    [0:`PCACR_NUM_MOD-1];
    logic [7:0]  own_rd_ff;
    logic [7:0]  nxt_own_rd;
    logic        mem_sel_ff;
    logic        nxt_mem_sel;
    logic        pend_ff;
    logic        nxt_pend;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [5:0]  lo_hit;
    logic [5:0]  hi_hit;
    logic [5:0]  mode_hit;
    logic        cap_hit;
    logic [4:0]  mem_idx;
    logic [7:0]  mem_rd;
    logic        hit_cnt_lo;
    logic        hit_cnt_hi;
    pcacr_pkg::pcacr_mem_wr_t mem_wr;

    // ========================================================================
    // Address decode
    function automatic logic [7:0] cap_addr(input int m, input logic hi);
        logic [7:0] a;
        a = `PCACR_UNMAPPED;
        case (m)
            0: a = hi ? `PCACR_ADDR_CPH0 : `PCACR_ADDR_CPL0;
            1: a = hi ? `PCACR_ADDR_CPH1 : `PCACR_ADDR_CPL1;
            2: a = hi ? `PCACR_ADDR_CPH2 : `PCACR_ADDR_CPL2;
            3: a = hi ? `PCACR_ADDR_CPH3 : `PCACR_ADDR_CPL3;
            4: a = hi ? `PCACR_ADDR_CPH4 : `PCACR_ADDR_CPL4;
            5: a = hi ? `PCACR_ADDR_CPH5 : `PCACR_ADDR_CPL5;
            default: a = `PCACR_UNMAPPED;
        endcase
        return a;
    endfunction

    for (genvar m = 0; m < `PCACR_NUM_MOD; m++) begin : g_dec
        assign lo_hit[m]   = (sfr_req.addr == cap_addr(m, 1'b0));
        assign hi_hit[m]   = (sfr_req.addr == cap_addr(m, 1'b1));
        assign mode_hit[m] = (sfr_req.addr == (`PCACR_ADDR_MODE0 + 8'(m)));
        assign mode_regs[8*m +: 8]  = mode_ff[m];
        assign compare_enable[m]    = mode_ff[m][`PCACR_CMP_EN_BIT];
    end

    assign hit_cnt_lo = (sfr_req.addr == `PCACR_ADDR_CNT_LO);
    assign hit_cnt_hi = (sfr_req.addr == `PCACR_ADDR_CNT_HI);
    assign cap_hit    = |(lo_hit | hi_hit);

    // The reload bank sits above the capture bank in the byte store.
    always_comb begin
        mem_idx = 5'h00;
        for (int m = 0; m < `PCACR_NUM_MOD; m++) begin
            if (lo_hit[m] || hi_hit[m]) begin
                mem_idx = 5'(2 * m) + 5'(hi_hit[m]);
            end
        end
        if (reload_select) begin
            mem_idx = mem_idx + `PCACR_RELOAD_BASE;
        end
    end

    // ========================================================================
    // Counter and snapshot
    always_comb begin
        nxt_counter = counter_ff + 16'(cnt_inc);
        nxt_snap    = snap_ff;
        if (sfr_req.wr && !wdt_enable && hit_cnt_lo) begin
            nxt_counter[7:0] = sfr_req.wdata;
        end
        if (sfr_req.wr && !wdt_enable && hit_cnt_hi) begin
            nxt_counter[15:8] = sfr_req.wdata;
        end
        if (sfr_req.rd && hit_cnt_lo) begin
            nxt_snap = counter_ff[15:8];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_ff <= `PCACR_RST_WORD;
            snap_ff    <= `PCACR_RST_BYTE;
        end else begin
            counter_ff <= nxt_counter;
            snap_ff    <= nxt_snap;
        end
    end

    assign array_counter = counter_ff;

    // ========================================================================
    // Mode registers and compare enable side effects
    always_comb begin
        for (int m = 0; m < `PCACR_NUM_MOD; m++) begin
            nxt_mode[m] = mode_ff[m];
            if (sfr_req.wr && mode_hit[m] && !(wdt_enable && (m == `PCACR_WDT_MOD))) begin
                nxt_mode[m] = sfr_req.wdata;
            end
            if (sfr_req.wr && lo_hit[m]) begin
                nxt_mode[m][`PCACR_CMP_EN_BIT] = 1'b0;
            end
            if (sfr_req.wr && hi_hit[m]) begin
                nxt_mode[m][`PCACR_CMP_EN_BIT] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int m = 0; m < `PCACR_NUM_MOD; m++) begin
                mode_ff[m] <= `PCACR_RST_BYTE;
            end
        end else begin
            for (int m = 0; m < `PCACR_NUM_MOD; m++) begin
                mode_ff[m] <= nxt_mode[m];
            end
        end
    end

    // ========================================================================
    // Capture/compare and reload byte store
    assign mem_wr.en   = sfr_req.wr && cap_hit;
    assign mem_wr.idx  = mem_idx;
    assign mem_wr.data = sfr_req.wdata;

    pcacr_ccmem u_ccmem (
        .clk           (clk),
        .rst_n         (rst_n),
        .wr            (mem_wr),
        .rd_en         (sfr_req.rd && cap_hit),
        .rd_idx        (mem_idx),
        .rd_data       (mem_rd),
        .cc_values     (cc_values),
        .reload_values (reload_values)
    );

    // ========================================================================
    // Read path: data appear two cycles after the read request.
    always_comb begin
        nxt_own_rd = `PCACR_UNMAPPED;
        if (hit_cnt_lo) begin
            nxt_own_rd = counter_ff[7:0];
        end
        if (hit_cnt_hi) begin
            nxt_own_rd = snap_ff;
        end
        for (int m = 0; m < `PCACR_NUM_MOD; m++) begin
            if (mode_hit[m]) begin
                nxt_own_rd = mode_ff[m];
            end
        end
        if (!sfr_req.rd) begin
            nxt_own_rd = own_rd_ff;
        end
        nxt_mem_sel = sfr_req.rd ? cap_hit : mem_sel_ff;
        nxt_pend    = sfr_req.rd;
        nxt_rdata   = pend_ff ? (mem_sel_ff ? mem_rd : own_rd_ff) : rdata_ff;
        nxt_rvalid  = pend_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            own_rd_ff  <= `PCACR_RST_BYTE;
            mem_sel_ff <= 1'b0;
            pend_ff    <= 1'b0;
            rdata_ff   <= `PCACR_RST_BYTE;
            rvalid_ff  <= 1'b0;
        end else begin
            own_rd_ff  <= nxt_own_rd;
            mem_sel_ff <= nxt_mem_sel;
            pend_ff    <= nxt_pend;
            rdata_ff   <= nxt_rdata;
            rvalid_ff  <= nxt_rvalid;
        end
    end

    assign sfr_rdata  = rdata_ff;
    assign sfr_rvalid = rvalid_ff;

    // ========================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rd_lo;
        sfr_req.rd && hit_cnt_lo;
    endsequence

    sequence s_rd_hi;
        sfr_req.rd && hit_cnt_hi;
    endsequence

    a_snap_load:  assert property (s_rd_lo |=> snap_ff == $past(counter_ff[15:8]))
        else $error("Snapshot not loaded on counter-low read.");

    a_snap_read:  assert property (s_rd_lo ##1 s_rd_hi |-> ##2 sfr_rdata == $past(snap_ff, 2))
        else $error("Counter-high read did not return the snapshot.");

    a_hi_write:   assert property (sfr_req.wr && hit_cnt_hi && !wdt_enable
                                   |=> counter_ff[15:8] == $past(sfr_req.wdata))
        else $error("Counter-high write lost.");

    a_hi_lock:    assert property (sfr_req.wr && (hit_cnt_hi || hit_cnt_lo) && wdt_enable
                                   |=> counter_ff == $past(counter_ff) + 16'($past(cnt_inc)))
        else $error("Counter changed by a write under watchdog lock.");

    a_lo_write:   assert property (sfr_req.wr && hit_cnt_lo && !wdt_enable
                                   |=> counter_ff[7:0] == $past(sfr_req.wdata))
        else $error("Counter-low write lost.");

    a_rd_latency: assert property (sfr_req.rd |-> ##2 sfr_rvalid)
        else $error("Read data not valid two cycles after request.");

    a_rd_spurious: assert property (!sfr_req.rd |-> ##2 !sfr_rvalid)
        else $error("Read valid without a read request two cycles before.");

    for (genvar m = 0; m < `PCACR_NUM_MOD; m++) begin : g_chk
        a_lo_clear:  assert property (sfr_req.wr && lo_hit[m] |=> !compare_enable[m])
            else $error("Capture-low write did not clear compare enable.");
        a_hi_set:    assert property (sfr_req.wr && hi_hit[m] |=> compare_enable[m])
            else $error("Capture-high write did not set compare enable.");
        a_cc_route:  assert property (sfr_req.wr && lo_hit[m] && !reload_select
                                      |=> cc_values[16*m +: 8] == $past(sfr_req.wdata))
            else $error("Capture-low byte not stored.");
        a_rl_route:  assert property (sfr_req.wr && hi_hit[m] && reload_select
                                      |=> reload_values[16*m+8 +: 8]
                                          == $past(sfr_req.wdata))
            else $error("Reload high byte not stored.");
    end

endmodule // pcacr_top

// File: tb/pcacr_top_test.sv
// Self-checking bench for the counter-array register block.
`timescale 1ns/1ps
`include "pcacr_defs.svh"

module pcacr_top_test;
    // ========================================================================
    // Signals and bench model
    logic                      clk;
    logic                      rst_n;
    pcacr_pkg::pcacr_sfr_req_t sfr_req;
    logic [7:0]                sfr_rdata;
    logic                      sfr_rvalid;
    logic                      wdt_enable;
    logic                      reload_select;
    logic                      cnt_inc;
    logic [15:0]               array_counter;
    logic [5:0]                compare_enable;
    logic [47:0]               mode_regs;
    logic [95:0]               cc_values;
    logic [95:0]               reload_values;
    int                        num_errors;
    int                        checks_done;
    logic [31:0]               seed;
    logic [15:0]               exp_cc [6];
    logic [15:0]               exp_rl [6];
    logic [5:0]                exp_ce;
    logic [15:0]               exp_cnt;
    logic [7:0]                lo_addr [6];
    logic [7:0]                hi_addr [6];

    pcacr_top dut (
        .clk            (clk),
        .rst_n          (rst_n),
        .sfr_req        (sfr_req),
        .sfr_rdata      (sfr_rdata),
        .sfr_rvalid     (sfr_rvalid),
        .wdt_enable     (wdt_enable),
        .reload_select  (reload_select),
        .cnt_inc        (cnt_inc),
        .array_counter  (array_counter),
        .compare_enable (compare_enable),
        .mode_regs      (mode_regs),
        .cc_values      (cc_values),
        .reload_values  (reload_values)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ========================================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic draw(output logic [31:0] r);
        seed = lfsr(seed);
        r = seed;
    endtask

    function automatic logic [15:0] pick(input logic sel, input logic [15:0] cc,
                                         input logic [15:0] rl);
        return sel ? rl : cc;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        sfr_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        int i;
        @(posedge clk);
        sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            if (sfr_rvalid === 1'b1) break;
        end
        chk("read strobe", 16'h0001, {15'h0000, sfr_rvalid});
        chk("read data", {8'h00, exp}, {8'h00, sfr_rdata});
    endtask

    task automatic clear_model();
        exp_cc  = '{default: 16'h0000};
        exp_rl  = '{default: 16'h0000};
        exp_ce  = 6'h00;
        exp_cnt = 16'h0000;
    endtask

    task automatic check_state();
        int m;
        for (m = 0; m < 6; m++) begin
            chk("capture value", exp_cc[m], cc_values[16*m +: 16]);
            chk("reload value", exp_rl[m], reload_values[16*m +: 16]);
            chk("mode bit", {15'h0000, exp_ce[m]}, {15'h0000, mode_regs[8*m+6]});
        end
        chk("compare enables", {10'h000, exp_ce}, {10'h000, compare_enable});
        chk("counter", exp_cnt, array_counter);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        int          m;
        int          k;
        logic [31:0] r;
        logic [15:0] v;
        sfr_req       = '0;
        wdt_enable    = 1'b0;
        reload_select = 1'b0;
        cnt_inc       = 1'b0;
        rst_n         = 1'b0;
        num_errors    = 0;
        checks_done   = 0;
        seed          = 32'hD37D3585;
        lo_addr = '{`PCACR_ADDR_CPL0, `PCACR_ADDR_CPL1, `PCACR_ADDR_CPL2,
                    `PCACR_ADDR_CPL3, `PCACR_ADDR_CPL4, `PCACR_ADDR_CPL5};
        hi_addr = '{`PCACR_ADDR_CPH0, `PCACR_ADDR_CPH1, `PCACR_ADDR_CPH2,
                    `PCACR_ADDR_CPH3, `PCACR_ADDR_CPH4, `PCACR_ADDR_CPH5};
        clear_model();
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check_state();
        for (m = 0; m < 6; m++) begin
            rd_chk(lo_addr[m], 8'h00);
            rd_chk(hi_addr[m], 8'h00);
        end
        rd_chk(`PCACR_ADDR_CNT_LO, 8'h00);
        rd_chk(`PCACR_ADDR_CNT_HI, 8'h00);
        rd_chk(8'hC0, 8'h00);
        // Random byte writes to all modules under both reload selections.
        for (k = 0; k < 60; k++) begin
            draw(r);
            m = int'(r[10:8]) % 6;
            @(posedge clk);
            reload_select <= r[16];
            if (r[17]) begin
                bus_wr(hi_addr[m], r[7:0]);
                if (r[16]) exp_rl[m][15:8] = r[7:0];
                else exp_cc[m][15:8] = r[7:0];
                exp_ce[m] = 1'b1;
            end else begin
                bus_wr(lo_addr[m], r[7:0]);
                if (r[16]) exp_rl[m][7:0] = r[7:0];
                else exp_cc[m][7:0] = r[7:0];
                exp_ce[m] = 1'b0;
            end
            check_state();
        end
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            reload_select <= k[0];
            for (m = 0; m < 6; m++) begin
                v = pick(k[0], exp_cc[m], exp_rl[m]);
                rd_chk(lo_addr[m], v[7:0]);
                rd_chk(hi_addr[m], v[15:8]);
            end
        end
        // Snapshot of the high byte is taken only by a low-byte read.
        bus_wr(`PCACR_ADDR_CNT_HI, 8'h12);
        bus_wr(`PCACR_ADDR_CNT_LO, 8'hFE);
        exp_cnt = 16'h12FE;
        check_state();
        rd_chk(`PCACR_ADDR_CNT_LO, 8'hFE);
        bus_wr(`PCACR_ADDR_CNT_HI, 8'h56);
        exp_cnt = 16'h56FE;
        rd_chk(`PCACR_ADDR_CNT_HI, 8'h12);
        draw(r);
        k = 2 + int'(r[3:0]);
        @(posedge clk);
        cnt_inc <= 1'b1;
        repeat (k) @(posedge clk);
        cnt_inc <= 1'b0;
        #1;
        exp_cnt = exp_cnt + 16'(k);
        check_state();
        rd_chk(`PCACR_ADDR_CNT_LO, exp_cnt[7:0]);
        rd_chk(`PCACR_ADDR_CNT_HI, exp_cnt[15:8]);
        // A low read followed at once by a high read returns a matching pair.
        @(posedge clk);
        sfr_req <= '{addr: `PCACR_ADDR_CNT_LO, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        sfr_req <= '{addr: `PCACR_ADDR_CNT_HI, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        sfr_req <= '{addr: `PCACR_ADDR_CNT_HI, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        #1;
        chk("pair low", {8'h00, exp_cnt[7:0]}, {8'h00, sfr_rdata});
        @(posedge clk);
        #1;
        chk("pair high", {8'h00, exp_cnt[15:8]}, {8'h00, sfr_rdata});
        // Counter writes are locked while the watchdog runs.
        @(posedge clk);
        wdt_enable <= 1'b1;
        bus_wr(`PCACR_ADDR_CNT_HI, ~exp_cnt[15:8]);
        bus_wr(`PCACR_ADDR_CNT_LO, ~exp_cnt[7:0]);
        bus_wr(`PCACR_ADDR_MODE0 + 8'h05, {1'b0, ~exp_ce[5], 6'h00});
        check_state();
        @(posedge clk);
        wdt_enable <= 1'b0;
        bus_wr(`PCACR_ADDR_CNT_HI, 8'hA5);
        exp_cnt[15:8] = 8'hA5;
        bus_wr(`PCACR_ADDR_MODE0 + 8'h05, 8'h40);
        exp_ce[5] = 1'b1;
        check_state();
        rd_chk(`PCACR_ADDR_MODE0 + 8'h05, 8'h40);
        // A second reset in mid-run clears everything again.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        clear_model();
        @(posedge clk);
        #1;
        check_state();
        rd_chk(`PCACR_ADDR_CNT_HI, 8'h00);
        results();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #200000;
        num_errors++;
        results();
    end

endmodule // pcacr_top_test
